/* qpdbi_regs.svh */
// Constants of the quad-pumped data path with group inversion.
`ifndef QPDBI_REGS_SVH
`define QPDBI_REGS_SVH
`define QPDBI_WORD_W     64
`define QPDBI_GROUP_W    16
`define QPDBI_GROUPS     4
`define QPDBI_XFERS      4
`define QPDBI_HALF       8
`define QPDBI_FIFO_DEPTH 4
`define QPDBI_CLK_NS     20
`define QPDBI_LINK_NS    160
`define QPDBI_BURST_CYC  ((`QPDBI_LINK_NS) / (`QPDBI_CLK_NS))
`define QPDBI_XFER_CYC   ((`QPDBI_BURST_CYC) / (`QPDBI_XFERS))
`define QPDBI_CNT_W      3
`endif

/* qpdbi_pkg.sv */
// Types of the quad-pumped data path with group inversion.
`default_nettype none
`include "qpdbi_regs.svh"
package qpdbi_pkg;
  typedef logic [`QPDBI_WORD_W-1:0] qpdbi_word_t;
  typedef logic [`QPDBI_GROUPS-1:0] qpdbi_grp_t;
  typedef struct packed
  {
    qpdbi_word_t data;
    qpdbi_grp_t  group_invert_flags;
    qpdbi_grp_t  strobe_pos;
    qpdbi_grp_t  strobe_neg;
    logic        data_valid_flag;
  } qpdbi_bus_t;
  typedef enum logic [1:0]
  {
    QPDBI_IDLE  = 2'b01,
    QPDBI_BURST = 2'b10
  } qpdbi_state_t;
endpackage
`default_nettype wire

/* qpdbi_top.sv */
// Transmit FIFO and quad-pumped bus end with per-group data inversion.
`timescale 1ns/1ps
`default_nettype none
`include "qpdbi_regs.svh"

module qpdbi_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  full_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [PW:0]   FULL = (PW + 1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  assign full_out      = (count == FULL);
  assign in_ready_out  = !full_out;
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb
  begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push)
    begin
      next_mem[wr_ptr] = in_data_in;
      next_wr_ptr      = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule

module qpdbi_top (
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  bus_clk_in,
  input  wire logic                  tx_valid_in,
  output logic                       tx_ready_out,
  input  wire qpdbi_pkg::qpdbi_word_t tx_data_in,
  output logic                       rx_valid_out,
  output qpdbi_pkg::qpdbi_word_t     rx_data_out,
  input  wire qpdbi_pkg::qpdbi_bus_t bus_in,
  output qpdbi_pkg::qpdbi_bus_t      bus_out,
  output logic                       bus_oe_out
);
  import qpdbi_pkg::*;
  localparam int GW = `QPDBI_GROUP_W;
  localparam logic [`QPDBI_CNT_W-1:0] LAST_CYC =
    `QPDBI_CNT_W'(`QPDBI_BURST_CYC - 1);
  localparam logic [`QPDBI_CNT_W-1:0] HALF_CYC =
    `QPDBI_CNT_W'(`QPDBI_BURST_CYC / 2);

  // Counts the bits that an active-low pin would drive low.
  function automatic logic over_half(input logic [GW-1:0] g);
    int n;
    n = 0;
    for (int i = 0; i < GW; i++)
    begin
      n = n + int'(g[i]);
    end
    return n > `QPDBI_HALF;
  endfunction

  function automatic qpdbi_grp_t inv_flags(input qpdbi_word_t w);
    qpdbi_grp_t f;
    for (int g = 0; g < `QPDBI_GROUPS; g++)
    begin
      f[g] = over_half(w[g*GW +: GW]);
    end
    return f;
  endfunction

  function automatic qpdbi_word_t apply_inv(input qpdbi_word_t w,
                                            input qpdbi_grp_t  f);
    qpdbi_word_t r;
    for (int g = 0; g < `QPDBI_GROUPS; g++)
    begin
      r[g*GW +: GW] = w[g*GW +: GW] ^ {GW{f[g]}};
    end
    return r;
  endfunction

  qpdbi_bus_t   sync1;
  qpdbi_bus_t   sync2;
  qpdbi_bus_t   sync3;
  logic [2:0]   bclk_sync;
  logic         bus_rise;
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sync1     <= '1;
      sync2     <= '1;
      sync3     <= '1;
      bclk_sync <= '0;
    end
    else
    begin
      sync1     <= bus_in;
      sync2     <= sync1;
      sync3     <= sync2;
      bclk_sync <= {bclk_sync[1:0], bus_clk_in};
    end
  end
  assign bus_rise = bclk_sync[1] && !bclk_sync[2];

  qpdbi_word_t  fifo_data;
  logic         fifo_valid;
  logic         fifo_full;
  logic         load;
  qpdbi_fifo #(
    .WIDTH (`QPDBI_WORD_W),
    .DEPTH (`QPDBI_FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .in_data_in    (tx_data_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (load),
    .out_data_out  (fifo_data),
    .full_out      (fifo_full)
  );

  qpdbi_state_t state;
  qpdbi_state_t next_state;
  logic [`QPDBI_CNT_W-1:0] cnt;
  logic [`QPDBI_CNT_W-1:0] next_cnt;
  qpdbi_word_t  tx_raw;
  qpdbi_word_t  next_tx_raw;
  qpdbi_bus_t   next_bus_out;
  logic         next_bus_oe;
  logic         start;
  logic [1:0]   ph;

  always_comb
  begin
    start = (state == QPDBI_IDLE || cnt == LAST_CYC) && bus_rise
            && fifo_full;
    load  = start || (state == QPDBI_BURST && cnt[0] && cnt != LAST_CYC);
    next_state  = start ? QPDBI_BURST
                : (cnt == LAST_CYC ? QPDBI_IDLE : state);
    next_cnt    = (start || state == QPDBI_IDLE) ? '0 : cnt + 1'b1;
    next_tx_raw = tx_raw;
    next_bus_out = bus_out;
    next_bus_oe  = (next_state == QPDBI_BURST);
    if (load)
    begin
      next_tx_raw = fifo_data;
      next_bus_out.group_invert_flags = ~inv_flags(fifo_data);
      next_bus_out.data = ~apply_inv(fifo_data, inv_flags(fifo_data));
    end
    next_bus_out.data_valid_flag = !next_bus_oe;
    ph = next_cnt[1:0];
    next_bus_out.strobe_pos = {`QPDBI_GROUPS{!(next_bus_oe
                              && (ph == 2'h1 || ph == 2'h2))}};
    next_bus_out.strobe_neg = {`QPDBI_GROUPS{!(next_bus_oe
                              && (ph == 2'h3 || next_cnt == HALF_CYC))}};
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state      <= QPDBI_IDLE;
      cnt        <= '0;
      tx_raw     <= '0;
      bus_out    <= '1;
      bus_oe_out <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      cnt        <= next_cnt;
      tx_raw     <= next_tx_raw;
      bus_out    <= next_bus_out;
      bus_oe_out <= next_bus_oe;
    end
  end

  qpdbi_grp_t   got;
  qpdbi_grp_t   next_got;
  qpdbi_grp_t   rx_fall;
  qpdbi_word_t  stage;
  qpdbi_word_t  next_stage;
  qpdbi_word_t  rx_true;
  logic         next_rx_valid;
  qpdbi_word_t  next_rx_data;

  always_comb
  begin
    rx_fall = ((sync3.strobe_pos & ~sync2.strobe_pos)
             | (sync3.strobe_neg & ~sync2.strobe_neg))
             & {`QPDBI_GROUPS{!sync2.data_valid_flag && !bus_oe_out}};
    rx_true    = apply_inv(~sync2.data, ~sync2.group_invert_flags);
    next_stage = stage;
    for (int g = 0; g < `QPDBI_GROUPS; g++)
    begin
      if (rx_fall[g])
      begin
        next_stage[g*GW +: GW] = rx_true[g*GW +: GW];
      end
    end
    next_rx_valid = &(got | rx_fall);
    next_got      = next_rx_valid ? '0 : (got | rx_fall);
    next_rx_data  = next_rx_valid ? next_stage : rx_data_out;
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      got          <= '0;
      stage        <= '0;
      rx_valid_out <= 1'b0;
      rx_data_out  <= '0;
    end
    else
    begin
      got          <= next_got;
      stage        <= next_stage;
      rx_valid_out <= next_rx_valid;
      rx_data_out  <= next_rx_data;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_quad_pop: assert property (start |-> ##2 load ##2 load ##2 load)
    else $error("Burst did not pop four words.");
  a_strobe_capture: assert property (rx_fall == 4'hf |=> rx_valid_out)
    else $error("Full strobe fall did not deliver a word.");
  a_group_three: assert property (
    bus_oe_out && !bus_out.group_invert_flags[3]
    |-> bus_out.data[63:48] == tx_raw[63:48])
    else $error("Group three not tied to flag three.");
  a_flag_polarity: assert property (bus_oe_out
    && bus_out.group_invert_flags[0] |-> bus_out.data[15:0] == ~tx_raw[15:0])
    else $error("Clear flag but group zero inverted.");
  a_invert_majority: assert property (bus_oe_out
    && !bus_out.group_invert_flags[0] |-> over_half(tx_raw[15:0]))
    else $error("Group inverted without a low majority.");
  a_flags_with_data: assert property (load
    |=> bus_out.group_invert_flags == ~inv_flags($past(fifo_data)))
    else $error("Flags not updated with their data.");
  a_valid_burst: assert property (start |=>
    (bus_oe_out && !bus_out.data_valid_flag)[*8])
    else $error("Data-valid dropped inside a burst.");
  a_round_trip: assert property (bus_oe_out
    |-> apply_inv(~bus_out.data, ~bus_out.group_invert_flags) == tx_raw)
    else $error("Driven word does not decode to its source.");
  a_group_indep: assert property (bus_oe_out
    |-> bus_out.group_invert_flags == ~inv_flags(tx_raw))
    else $error("Group inversion not chosen per group.");

  c_burst: cover property (start ##8 start);
  c_rx_word: cover property (rx_valid_out);
  c_inverted: cover property (bus_oe_out && bus_out.group_invert_flags != 4'hf);
endmodule
`default_nettype wire

/* qpdbi_agent.sv */
// Far-side bus agent model that sends and decodes quad-pumped bursts.
`timescale 1ns/1ps
`default_nettype none
module qpdbi_agent (
  input  wire logic                  clk_in,
  input  wire logic                  oe_in,
  input  wire qpdbi_pkg::qpdbi_bus_t line_in,
  output qpdbi_pkg::qpdbi_bus_t      drive_out,
  output logic                       got_valid_out,
  output qpdbi_pkg::qpdbi_word_t     got_word_out,
  output logic                       got_ok_out
);
  import qpdbi_pkg::*;
  qpdbi_bus_t  prev;
  qpdbi_word_t w;
  logic        ok;
  initial
  begin
    drive_out = '1;
    prev = '1;
    got_valid_out = 1'b0;
  end
  // inversion only above eight low bits.
  function automatic qpdbi_grp_t inv_of(input qpdbi_word_t v);
    for (int g = 0; g < 4; g++)
      inv_of[g] = $countones(v[g*16 +: 16]) > 8;
  endfunction
  // group n owns bits 16n and up.
  function automatic qpdbi_word_t spread(input qpdbi_grp_t f);
    return {{16{f[3]}}, {16{f[2]}}, {16{f[1]}}, {16{f[0]}}};
  endfunction
  // four transfers, flags with data, strobes alternate.
  task automatic send(input qpdbi_word_t wd [4], input logic dv);
    qpdbi_grp_t f;
    for (int k = 0; k < 4; k++)
    begin
      f = inv_of(wd[k]);
      @(negedge clk_in);
      drive_out.data = ~(wd[k] ^ spread(f));
      drive_out.group_invert_flags = ~f;
      drive_out.data_valid_flag = ~dv;
      drive_out.strobe_pos = '1;
      drive_out.strobe_neg = '1;
      @(negedge clk_in);
      if (k[0])
        drive_out.strobe_neg = '0;
      else
        drive_out.strobe_pos = '0;
      repeat (2) @(negedge clk_in);
    end
    @(negedge clk_in);
    drive_out = '1;
  endtask
  // decode each strobe fall of the driving end.
  always @(posedge clk_in)
  begin
    prev <= line_in;
    got_valid_out <= 1'b0;
    if (oe_in && ((prev.strobe_pos[0] && !line_in.strobe_pos[0]) ||
        (prev.strobe_neg[0] && !line_in.strobe_neg[0])))
    begin
      w = ~line_in.data ^ spread(~line_in.group_invert_flags);
      ok = (~line_in.group_invert_flags === inv_of(w)) &&
           !line_in.data_valid_flag &&
           (line_in.strobe_pos === {4{line_in.strobe_pos[0]}}) &&
           (line_in.strobe_neg === {4{line_in.strobe_neg[0]}});
      got_word_out <= w;
      got_ok_out <= ok;
      got_valid_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* qpdbi_top_test.sv */
// Self-checking bench of the quad-pumped data path with group inversion.
`timescale 1ns/1ps
`default_nettype none
module qpdbi_top_test;
  import qpdbi_pkg::*;
  logic        clk_in, reset_in, bus_clk_in, tx_valid_in, tx_ready_out;
  logic        rx_valid_out, bus_oe_out, got_valid, got_ok;
  qpdbi_word_t tx_data_in, rx_data_out, got_word;
  qpdbi_bus_t  bus_in, bus_out;
  qpdbi_word_t tx_q[$], rx_q[$], ws[$], wd [4];
  int          err_total, n_compared;
  logic [31:0] seed;
  qpdbi_top uut (.clk_in(clk_in), .reset_in(reset_in),
    .bus_clk_in(bus_clk_in), .tx_valid_in(tx_valid_in),
    .tx_ready_out(tx_ready_out), .tx_data_in(tx_data_in),
    .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe_out(bus_oe_out));
  qpdbi_agent agent (.clk_in(clk_in), .oe_in(bus_oe_out), .line_in(bus_out),
    .drive_out(bus_in), .got_valid_out(got_valid), .got_word_out(got_word),
    .got_ok_out(got_ok));
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial
  begin
    bus_clk_in = 1'b0;
    #7;
    forever #80 bus_clk_in = ~bus_clk_in;
  end
  function automatic qpdbi_word_t rnd();
    for (int i = 0; i < 2; i++)
    begin
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      rnd[i*32 +: 32] = seed;
    end
  endfunction
  task automatic check(input qpdbi_word_t seen, input qpdbi_word_t exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic put_words();
    int t;
    foreach (ws[i])
    begin
      @(negedge clk_in);
      tx_data_in = ws[i];
      tx_valid_in = 1'b1;
      t = 0;
      while (!tx_ready_out && t < 100)
      begin
        @(negedge clk_in);
        t++;
      end
      if (t == 100)
      begin
        err_total++;
        stop_test();
      end
      @(posedge clk_in);
      tx_q.push_back(tx_data_in);
    end
    @(negedge clk_in);
    tx_valid_in = 1'b0;
  endtask
  task automatic drain();
    int t;
    t = 0;
    while ((tx_q.size() || rx_q.size()) && t < 400)
    begin
      @(negedge clk_in);
      t++;
    end
    if (t == 400)
    begin
      err_total++;
      stop_test();
    end
  endtask
  always @(posedge clk_in)
  begin
    if (got_valid === 1'b1)
    begin
      check(got_word, tx_q.size() ? tx_q.pop_front() : ~got_word);
      check(got_ok, 1'b1);
    end
    if (rx_valid_out === 1'b1)
      check(rx_data_out, rx_q.size() ? rx_q.pop_front() : ~rx_data_out);
  end
  initial
  begin
    seed = 32'h38b87240;
    reset_in = 1'b1;
    tx_valid_in = 1'b0;
    tx_data_in = '0;
    err_total = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    check({bus_oe_out, tx_ready_out, rx_valid_out}, 3'b010);
    check(bus_out.data, '1);
    reset_in = 1'b0;
    ws = '{64'h01ff_00ff_ffff_0000, 64'hfe00_ff00_0000_ffff,
           64'h8000_7fff_0001_fffe, rnd()};
    put_words();
    check(tx_ready_out, 1'b0);
    ws = '{rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    put_words();
    drain();
    for (int b = 0; b < 3; b++)
    begin
      foreach (wd[k])
        wd[k] = (b == 0) ? {4{16'h00ff << k}} : rnd();
      if (b < 2)
        foreach (wd[k])
          rx_q.push_back(wd[k]);
      agent.send(wd, b < 2);
      drain();
    end
    repeat (20) @(negedge clk_in);
    stop_test();
  end
endmodule
`default_nettype wire
